// ---- logic/hax_dev.sv ----
// Hash authentication engine with a banked byte memory behind an index and data window.
// Assumes a host on the same clock issuing single-cycle register strobes.
//
// How it works
// - Host loads 160-bit challenge before starting.
// - Command 0x35 includes serial, next excludes.
// - Command and challenge before go with enable.
// - Host reads 256-bit digest after done.
// - Host alone judges pass or fail.
// - Outcome never changes any other function.
// - Enable field 0 disables, 1 enables.
// - Go bit clears itself when digest done.
// - Window writes only while write permit set.
// - Bank bit picks low or high bank.
// - Burst past 0xFF sets bank bit.
// - Memory is 384 bytes in two banks.
// - Index gives burst start within bank.
// - Address saturates at top location 0x17F.
// - Window stays, memory address steps per byte.
// - Read-only fixed chip type identifier.
// - Challenge and digest sit at memory base.
// - SHA-256 over secret, challenge, constant block.
// - Serial replaces 64 constant bits on 0x35.
module hax_dev #(
	parameter logic [7:0]   CHIP_IDENT = 8'hA5, // Arbitrary value.
	parameter logic [191:0] CONST_DATA = {6{32'h5A5A_C33C}}
) (
	// Clock and reset.
	input  wire  logic         CLK,
	input  wire  logic         RST,
	// Register port.
	hax_if.dev                 BUS,
	// Per-chip secret and serial.
	input  wire  logic [159:0] SECRET,
	input  wire  logic [63:0]  UNIQUE_SERIAL,
	// Status.
	output logic               BUSY
);
	localparam logic [31:0] H0 [8] = '{32'h6a09_e667, 32'hbb67_ae85, 32'h3c6e_f372, 32'ha54f_f53a,
		32'h510e_527f, 32'h9b05_688c, 32'h1f83_d9ab, 32'h5be0_cd19};
	localparam logic [31:0] K [64] = '{
		32'h428a_2f98, 32'h7137_4491, 32'hb5c0_fbcf, 32'he9b5_dba5, 32'h3956_c25b, 32'h59f1_11f1, 32'h923f_82a4,
		32'hab1c_5ed5, 32'hd807_aa98, 32'h1283_5b01, 32'h2431_85be, 32'h550c_7dc3, 32'h72be_5d74, 32'h80de_b1fe,
		32'h9bdc_06a7, 32'hc19b_f174, 32'he49b_69c1, 32'hefbe_4786, 32'h0fc1_9dc6, 32'h240c_a1cc, 32'h2de9_2c6f,
		32'h4a74_84aa, 32'h5cb0_a9dc, 32'h76f9_88da, 32'h983e_5152, 32'ha831_c66d, 32'hb003_27c8, 32'hbf59_7fc7,
		32'hc6e0_0bf3, 32'hd5a7_9147, 32'h06ca_6351, 32'h1429_2967, 32'h27b7_0a85, 32'h2e1b_2138, 32'h4d2c_6dfc,
		32'h5338_0d13, 32'h650a_7354, 32'h766a_0abb, 32'h81c2_c92e, 32'h9272_2c85, 32'ha2bf_e8a1, 32'ha81a_664b,
		32'hc24b_8b70, 32'hc76c_51a3, 32'hd192_e819, 32'hd699_0624, 32'hf40e_3585, 32'h106a_a070, 32'h19a4_c116,
		32'h1e37_6c08, 32'h2748_774c, 32'h34b0_bcb5, 32'h391c_0cb3, 32'h4ed8_aa4a, 32'h5b9c_ca4f, 32'h682e_6ff3,
		32'h748f_82ee, 32'h78a5_636f, 32'h84c8_7814, 32'h8cc7_0208, 32'h90be_fffa, 32'ha450_6ceb, 32'hbef9_a3f7,
		32'hc671_78f2};

	function automatic logic [31:0] rotr(input logic [31:0] x, input int n);
		return (x >> n) | (x << (32 - n));
	endfunction

	typedef enum {HAX_IDLE, HAX_LOAD, HAX_ROUND, HAX_SUM, HAX_STORE} hax_state_t;

	logic [7:0]  mem [hax_pkg::MEM_BYTES];
	// Register group.
	logic [7:0]  cmd, next_cmd;
	logic        en, next_en, go, next_go, wr_en, next_wr_en, bank, next_bank, irq_en, next_irq_en;
	logic [7:0]  index, next_index, rdata, next_rdata;
	logic        rvalid, next_rvalid, done, next_done;
	// Engine group.
	hax_state_t  state, next_state;
	logic [5:0]  cnt, next_cnt;
	logic [159:0] chal, next_chal;
	logic [31:0] v [8];
	logic [31:0] next_v [8];
	logic [31:0] w [16];
	logic [31:0] next_w [16];
	logic [255:0] dig, next_dig;
	logic        finish, abort, eng_we;
	logic [8:0]  eng_addr;
	// Memory port shared by window and engine.
	logic        host_we;
	logic [8:0]  ptr, eff;
	logic [511:0] msg;

	assign ptr = {bank, index};
	assign eff = (ptr > hax_pkg::MEM_TOP) ? hax_pkg::MEM_TOP : ptr;

	always_comb begin
		logic win;
		logic [8:0] step;
		win = (BUS.wr || BUS.rd) && BUS.addr == hax_pkg::A_MDATA;
		step = (eff < hax_pkg::MEM_TOP) ? eff + 9'h001 : hax_pkg::MEM_TOP;
		next_cmd = cmd;
		next_en = en;
		next_go = go;
		next_wr_en = wr_en;
		next_bank = bank;
		next_index = index;
		next_irq_en = irq_en;
		next_rdata = rdata;
		next_rvalid = BUS.rd;
		next_done = 1'b0;
		host_we = BUS.wr && BUS.addr == hax_pkg::A_MDATA && wr_en;
		// Hardware clears go before the bus write is applied, so a go write in the same cycle wins.
		if (finish) begin
			next_go = 1'b0;
			next_done = irq_en;
		end else if (abort || (go && state == HAX_IDLE && cmd != hax_pkg::CMD_MAC_SER
				&& cmd != hax_pkg::CMD_MAC_NOSER)) begin
			// A bad command or a dropped enable ends the run silently.
			next_go = 1'b0;
		end
		if (BUS.wr) begin
			case (BUS.addr)
				hax_pkg::A_CMD: next_cmd = BUS.wdata;
				hax_pkg::A_CFG: begin
					next_en = BUS.wdata[hax_pkg::CFG_EN_BIT];
					// Go is only raised together with enable and never lowered by software.
					if (BUS.wdata[hax_pkg::CFG_GO_BIT] && BUS.wdata[hax_pkg::CFG_EN_BIT])
						next_go = 1'b1;
				end
				hax_pkg::A_MCTL: begin
					next_wr_en = BUS.wdata[hax_pkg::MCTL_WREN_BIT];
					next_bank = BUS.wdata[hax_pkg::MCTL_BANK_BIT];
				end
				hax_pkg::A_MIDX: next_index = BUS.wdata;
				hax_pkg::A_IRQEN: next_irq_en = BUS.wdata[hax_pkg::IRQEN_DONE_BIT];
				default: ;
			endcase
		end
		if (win) begin
			// The register address stays on the window; only the memory pointer moves.
			{next_bank, next_index} = step;
		end
		if (BUS.rd) begin
			case (BUS.addr)
				hax_pkg::A_CMD: next_rdata = cmd;
				hax_pkg::A_CFG: next_rdata = {6'h00, en, go};
				hax_pkg::A_MCTL: next_rdata = {6'h00, wr_en, bank};
				hax_pkg::A_MIDX: next_rdata = index;
				hax_pkg::A_MDATA: next_rdata = mem[eff];
				hax_pkg::A_IRQEN: next_rdata = {7'h00, irq_en};
				hax_pkg::A_CHIPID: next_rdata = CHIP_IDENT;
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			cmd <= hax_pkg::RST_CMD;
			en <= hax_pkg::EN_OFF;
			go <= 1'b0;
			wr_en <= 1'b0;
			bank <= 1'b0;
			index <= hax_pkg::RST_MIDX;
			irq_en <= 1'b0;
			rdata <= hax_pkg::RST_RDATA;
			rvalid <= 1'b0;
			done <= 1'b0;
		end else begin
			cmd <= next_cmd;
			en <= next_en;
			go <= next_go;
			wr_en <= next_wr_en;
			bank <= next_bank;
			index <= next_index;
			irq_en <= next_irq_en;
			rdata <= next_rdata;
			rvalid <= next_rvalid;
			done <= next_done;
		end
	end

	// The engine wins the memory while storing; a window write in that cycle is dropped.
	always_ff @(posedge CLK) begin
		if (eng_we)
			mem[eng_addr] <= dig[255:248];
		else if (host_we)
			mem[eff] <= BUS.wdata;
	end

	assign msg = (cmd == hax_pkg::CMD_MAC_SER) ? {SECRET, next_chal, UNIQUE_SERIAL, CONST_DATA[127:0]}
		: {SECRET, next_chal, CONST_DATA};

	always_comb begin
		logic [31:0] t1, t2, ws;
		next_state = state;
		next_cnt = cnt;
		next_chal = chal;
		next_v = v;
		next_w = w;
		next_dig = dig;
		finish = 1'b0;
		abort = 1'b0;
		eng_we = 1'b0;
		eng_addr = hax_pkg::DIGEST_BASE + {3'h0, cnt};
		t1 = v[7] + (rotr(v[4], 6) ^ rotr(v[4], 11) ^ rotr(v[4], 25)) + ((v[4] & v[5]) ^ (~v[4] & v[6]))
			+ K[cnt] + w[0];
		t2 = (rotr(v[0], 2) ^ rotr(v[0], 13) ^ rotr(v[0], 22)) + ((v[0] & v[1]) ^ (v[0] & v[2]) ^ (v[1] & v[2]));
		ws = (rotr(w[14], 17) ^ rotr(w[14], 19) ^ (w[14] >> 10)) + w[9]
			+ (rotr(w[1], 7) ^ rotr(w[1], 18) ^ (w[1] >> 3)) + w[0];
		case (state)
			HAX_IDLE: begin
				// The engine only starts with enable on and a known command.
				if (go && en == hax_pkg::EN_ON && (cmd == hax_pkg::CMD_MAC_SER || cmd == hax_pkg::CMD_MAC_NOSER)) begin
					next_state = HAX_LOAD;
					next_cnt = 6'h00;
				end
			end
			HAX_LOAD: begin
				next_chal = {chal[151:0], mem[hax_pkg::CHAL_BASE + {3'h0, cnt}]};
				next_cnt = cnt + 6'h01;
				if (cnt == 6'(hax_pkg::CHAL_BYTES - 1)) begin
					next_state = HAX_ROUND;
					next_cnt = 6'h00;
					next_v = H0;
					for (int i = 0; i < 16; i++)
						next_w[i] = msg[511 - 32 * i -: 32];
				end
			end
			HAX_ROUND: begin
				next_v = '{t1 + t2, v[0], v[1], v[2], v[3] + t1, v[4], v[5], v[6]};
				for (int i = 0; i < 15; i++)
					next_w[i] = w[i + 1];
				next_w[15] = ws;
				next_cnt = cnt + 6'h01;
				if (cnt == 6'(hax_pkg::ROUNDS - 1))
					next_state = HAX_SUM;
			end
			HAX_SUM: begin
				for (int i = 0; i < 8; i++)
					next_dig[255 - 32 * i -: 32] = H0[i] + v[i];
				next_cnt = 6'h00;
				next_state = HAX_STORE;
			end
			HAX_STORE: begin
				eng_we = 1'b1;
				next_dig = {dig[247:0], 8'h00};
				next_cnt = cnt + 6'h01;
				if (cnt == 6'(hax_pkg::DIGEST_BYTES - 1)) begin
					finish = 1'b1;
					next_state = HAX_IDLE;
				end
			end
			default: next_state = HAX_IDLE;
		endcase
		// Whatever the digest turns out to be, nothing outside the engine reacts to it.
		if (state != HAX_IDLE && en == hax_pkg::EN_OFF) begin
			abort = 1'b1;
			eng_we = 1'b0;
			finish = 1'b0;
			next_state = HAX_IDLE;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			state <= HAX_IDLE;
			cnt <= 6'h00;
			BUSY <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			BUSY <= next_state != HAX_IDLE;
		end
		chal <= next_chal;
		v <= next_v;
		w <= next_w;
		dig <= next_dig;
	end

	assign BUS.rdata = rdata;
	assign BUS.rvalid = rvalid;
	assign BUS.done = done;
endmodule

// ---- logic/hax_host.sv ----
// Host sequencer: loads a challenge, runs the engine, reads back and checks the digest.
// Assumes the engine answers reads one cycle after the strobe and pulses done at the end.
module hax_host (
	// Clock and reset.
	input  wire  logic         CLK,
	input  wire  logic         RST,
	// Register port.
	hax_if.host                BUS,
	// User request.
	input  wire  logic         START,
	input  wire  logic         WITH_SERIAL,
	input  wire  logic [159:0] CHALLENGE,
	input  wire  logic [255:0] EXPECTED,
	// User answer.
	output logic [255:0]       DIGEST,
	output logic               DONE,
	output logic               PASS,
	output logic               BUSY
);
	typedef enum {HH_IDLE, HH_SETUP, HH_CHAL, HH_CMD, HH_GO, HH_WAIT, HH_PTR, HH_READ, HH_OFF} hax_seq_t;

	hax_seq_t     state, next_state;
	logic [5:0]   cnt, next_cnt;
	logic         pend, next_pend;
	logic [159:0] chal, next_chal;
	logic         ser, next_ser;
	logic         wr, next_wr, rd, next_rd;
	logic [7:0]   addr, next_addr, wdata, next_wdata;
	logic [255:0] next_digest;
	logic         next_done, next_pass;

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_pend = pend;
		next_chal = chal;
		next_ser = ser;
		next_wr = 1'b0;
		next_rd = 1'b0;
		next_addr = addr;
		next_wdata = wdata;
		next_digest = DIGEST;
		next_done = 1'b0;
		next_pass = PASS;
		case (state)
			HH_IDLE: begin
				if (START) begin
					next_chal = CHALLENGE;
					next_ser = WITH_SERIAL;
					next_cnt = 6'h00;
					next_state = HH_SETUP;
				end
			end
			HH_SETUP: begin
				next_wr = 1'b1;
				case (cnt)
					6'h00: {next_addr, next_wdata} = {hax_pkg::A_IRQEN, hax_pkg::IRQEN_DONE};
					6'h01: {next_addr, next_wdata} = {hax_pkg::A_CFG, hax_pkg::CFG_EN_ONLY};
					6'h02: {next_addr, next_wdata} = {hax_pkg::A_MCTL, hax_pkg::MCTL_WR_BANK0};
					default: {next_addr, next_wdata} = {hax_pkg::A_MIDX, hax_pkg::RST_MIDX};
				endcase
				next_cnt = cnt + 6'h01;
				if (cnt == 6'(hax_pkg::SETUP_WRITES - 1)) begin
					next_cnt = 6'h00;
					next_state = HH_CHAL;
				end
			end
			HH_CHAL: begin
				next_wr = 1'b1;
				next_addr = hax_pkg::A_MDATA;
				next_wdata = chal[159:152];
				next_chal = {chal[151:0], 8'h00};
				next_cnt = cnt + 6'h01;
				if (cnt == 6'(hax_pkg::CHAL_BYTES - 1))
					next_state = HH_CMD;
			end
			HH_CMD: begin
				next_wr = 1'b1;
				next_addr = hax_pkg::A_CMD;
				next_wdata = ser ? hax_pkg::CMD_MAC_SER : hax_pkg::CMD_MAC_NOSER;
				next_state = HH_GO;
			end
			HH_GO: begin
				next_wr = 1'b1;
				next_addr = hax_pkg::A_CFG;
				next_wdata = hax_pkg::CFG_EN_GO;
				next_state = HH_WAIT;
			end
			HH_WAIT: begin
				if (BUS.done) begin
					next_cnt = 6'h00;
					next_state = HH_PTR;
				end
			end
			HH_PTR: begin
				next_wr = 1'b1;
				{next_addr, next_wdata} = (cnt == 6'h00) ? {hax_pkg::A_MCTL, hax_pkg::MCTL_WR_BANK0}
					: {hax_pkg::A_MIDX, hax_pkg::RST_MIDX};
				next_cnt = cnt + 6'h01;
				if (cnt == 6'h01) begin
					next_cnt = 6'h00;
					next_pend = 1'b0;
					next_state = HH_READ;
				end
			end
			HH_READ: begin
				next_addr = hax_pkg::A_MDATA;
				if (!pend) begin
					next_rd = 1'b1;
					next_pend = 1'b1;
				end else if (BUS.rvalid) begin
					next_digest = {DIGEST[247:0], BUS.rdata};
					next_pend = 1'b0;
					next_cnt = cnt + 6'h01;
					if (cnt == 6'(hax_pkg::DIGEST_BYTES - 1))
						next_state = HH_OFF;
				end
			end
			HH_OFF: begin
				next_wr = 1'b1;
				next_addr = hax_pkg::A_CFG;
				next_wdata = hax_pkg::CFG_OFF;
				next_pass = DIGEST == EXPECTED;
				next_done = 1'b1;
				next_state = HH_IDLE;
			end
			default: next_state = HH_IDLE;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			state <= HH_IDLE;
			cnt <= 6'h00;
			pend <= 1'b0;
			chal <= 160'h0;
			ser <= 1'b0;
			wr <= 1'b0;
			rd <= 1'b0;
			addr <= 8'h00;
			wdata <= 8'h00;
			DIGEST <= 256'h0;
			DONE <= 1'b0;
			PASS <= 1'b0;
			BUSY <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			pend <= next_pend;
			chal <= next_chal;
			ser <= next_ser;
			wr <= next_wr;
			rd <= next_rd;
			addr <= next_addr;
			wdata <= next_wdata;
			DIGEST <= next_digest;
			DONE <= next_done;
			PASS <= next_pass;
			BUSY <= next_state != HH_IDLE;
		end
	end

	assign BUS.wr = wr;
	assign BUS.rd = rd;
	assign BUS.addr = addr;
	assign BUS.wdata = wdata;
endmodule

// ---- logic/hax_if.sv ----
// Register port between the host sequencer and the hash engine.
// Assumes both parties sample on the same clock edge.
interface hax_if;
	logic       wr;
	logic       rd;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       rvalid;
	logic       done;
	modport dev  (input wr, input rd, input addr, input wdata, output rdata, output rvalid, output done);
	modport host (output wr, output rd, output addr, output wdata, input rdata, input rvalid, input done);
endinterface

// ---- logic/hax_pkg.sv ----
// Shared constants of the challenge-response hash engine and its host sequencer.
// Assumes both ends run on one clock with a synchronous active-high reset.
package hax_pkg;
	// Register addresses on the byte-wide register port.
	localparam logic [7:0] A_CMD    = 8'hF0;
	localparam logic [7:0] A_CFG    = 8'hF1;
	localparam logic [7:0] A_MCTL   = 8'hF2;
	localparam logic [7:0] A_MIDX   = 8'hF3;
	localparam logic [7:0] A_MDATA  = 8'hF4;
	localparam logic [7:0] A_IRQEN  = 8'hF5;
	localparam logic [7:0] A_CHIPID = 8'hFF;
	// Field positions.
	localparam int CFG_GO_BIT    = 0;
	localparam int CFG_EN_BIT    = 1;
	localparam int MCTL_BANK_BIT = 0;
	localparam int MCTL_WREN_BIT = 1;
	localparam int IRQEN_DONE_BIT = 0;
	// Field values.
	localparam logic       EN_OFF        = 1'b0;
	localparam logic       EN_ON         = 1'b1;
	localparam logic [7:0] CMD_MAC_SER   = 8'h35;
	localparam logic [7:0] CMD_MAC_NOSER = CMD_MAC_SER + 8'h01;
	localparam logic [7:0] CFG_EN_ONLY   = 8'h02;
	localparam logic [7:0] CFG_EN_GO     = 8'h03;
	localparam logic [7:0] CFG_OFF       = 8'h00;
	localparam logic [7:0] MCTL_WR_BANK0 = 8'h02;
	localparam logic [7:0] IRQEN_DONE    = 8'h01;
	// Reset values.
	localparam logic [7:0] RST_CMD  = 8'h00;
	localparam logic [7:0] RST_MIDX = 8'h00;
	localparam logic [7:0] RST_RDATA = 8'h00;
	// Memory layout and counts.
	localparam int          MEM_BYTES    = 384;
	localparam int          BANK0_BYTES  = 256;
	localparam int          BANK1_BYTES  = 128;
	localparam logic [8:0]  MEM_TOP      = 9'h17F;
	localparam logic [8:0]  CHAL_BASE    = 9'h000;
	localparam logic [8:0]  DIGEST_BASE  = 9'h000;
	localparam int          CHAL_BYTES   = 20;
	localparam int          DIGEST_BYTES = 32;
	localparam int          ROUNDS       = 64;
	localparam int          SETUP_WRITES = 4;
endpackage

// ---- tb/hax_properties.sv ----
// Concurrent checks on the register port that joins the host sequencer to the hash engine.
// Assumes one clock and a synchronous active-high reset shared by both ends.
module hax_properties (
	// Clock and reset.
	input wire logic       CLK,
	input wire logic       RST,
	// Host requests.
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	// Engine answers.
	input wire logic [7:0] rdata,
	input wire logic       rvalid,
	input wire logic       done
);
	timeunit 1ns;
	timeprecision 1ps;
	// The shortest run is challenge load, rounds, sum and store; the upper bound leaves slack for start-up.
	localparam int RUN_MIN = 117;
	localparam int RUN_MAX = 140;
	logic go_m;
	logic en_m;
	logic go_wr;
	assign go_wr = wr && addr == hax_pkg::A_CFG && wdata == hax_pkg::CFG_EN_GO;
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	always_ff @(posedge CLK) begin
		if (RST) begin
			go_m <= 1'b0;
			en_m <= 1'b0;
		end else if (wr && addr == hax_pkg::A_CFG) begin
			go_m <= wdata[hax_pkg::CFG_GO_BIT] && wdata[hax_pkg::CFG_EN_BIT];
			en_m <= wdata[hax_pkg::CFG_EN_BIT];
		end else if (done) begin
			go_m <= 1'b0;
		end
	end
	a_rvalid_after: assert property (rd |=> rvalid)
		else $error("read strobe not answered in the next cycle");
	a_rvalid_cause: assert property (rvalid |-> $past(rd))
		else $error("read answer without a read strobe");
	a_digest_read: assert property (done |-> ##[1:8] (rd && addr == hax_pkg::A_MDATA))
		else $error("digest readout did not start after done");
	a_cmd_code: assert property (wr && addr == hax_pkg::A_CMD |->
		wdata == hax_pkg::CMD_MAC_SER || wdata == hax_pkg::CMD_MAC_NOSER)
		else $error("command code outside the two valid codes");
	a_go_with_en: assert property (wr && addr == hax_pkg::A_CFG && wdata[hax_pkg::CFG_GO_BIT] |->
		wdata[hax_pkg::CFG_EN_BIT])
		else $error("go written without enable");
	a_done_pulse: assert property (done |=> !done)
		else $error("done longer than one cycle");
	a_done_after_go: assert property (done |-> go_m)
		else $error("done without an outstanding start");
	a_done_enabled: assert property (done |-> en_m)
		else $error("done while the engine is disabled");
	a_run_length: assert property (go_wr |-> ##[RUN_MIN:RUN_MAX] done)
		else $error("digest run length out of range");
	a_idle_after: assert property (done |->
		##[60:120] (wr && addr == hax_pkg::A_CFG && wdata == hax_pkg::CFG_OFF))
		else $error("engine not disabled after readout");
	c_go: cover property (go_wr);
	c_done: cover property (done);
	c_digest_rd: cover property (rd && addr == hax_pkg::A_MDATA);
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench: host sequencer against one engine, a second engine driven register by register.
// Assumes the package, the interface and both design modules are compiled first.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0]   IDENT = 8'h5C; // Arbitrary value.
	localparam logic [191:0] CDATA = {6{32'h3C96_0F1E}};
	localparam logic [31:0]  IV [8] = '{32'h6a09_e667,32'hbb67_ae85,32'h3c6e_f372,32'ha54f_f53a,
		32'h510e_527f,32'h9b05_688c,32'h1f83_d9ab,32'h5be0_cd19};
	localparam logic [31:0]  K [64] = '{
		32'h428a_2f98,32'h7137_4491,32'hb5c0_fbcf,32'he9b5_dba5,32'h3956_c25b,32'h59f1_11f1,32'h923f_82a4,32'hab1c_5ed5,
		32'hd807_aa98,32'h1283_5b01,32'h2431_85be,32'h550c_7dc3,32'h72be_5d74,32'h80de_b1fe,32'h9bdc_06a7,32'hc19b_f174,
		32'he49b_69c1,32'hefbe_4786,32'h0fc1_9dc6,32'h240c_a1cc,32'h2de9_2c6f,32'h4a74_84aa,32'h5cb0_a9dc,32'h76f9_88da,
		32'h983e_5152,32'ha831_c66d,32'hb003_27c8,32'hbf59_7fc7,32'hc6e0_0bf3,32'hd5a7_9147,32'h06ca_6351,32'h1429_2967,
		32'h27b7_0a85,32'h2e1b_2138,32'h4d2c_6dfc,32'h5338_0d13,32'h650a_7354,32'h766a_0abb,32'h81c2_c92e,32'h9272_2c85,
		32'ha2bf_e8a1,32'ha81a_664b,32'hc24b_8b70,32'hc76c_51a3,32'hd192_e819,32'hd699_0624,32'hf40e_3585,32'h106a_a070,
		32'h19a4_c116,32'h1e37_6c08,32'h2748_774c,32'h34b0_bcb5,32'h391c_0cb3,32'h4ed8_aa4a,32'h5b9c_ca4f,32'h682e_6ff3,
		32'h748f_82ee,32'h78a5_636f,32'h84c8_7814,32'h8cc7_0208,32'h90be_fffa,32'ha450_6ceb,32'hbef9_a3f7,32'hc671_78f2};
	logic         clk = 1'b0;
	logic         rst = 1'b1;
	logic         start = 1'b0;
	logic         with_ser = 1'b0;
	logic [159:0] chal = '0;
	logic [255:0] exp_dig = '0;
	logic [159:0] secret;
	logic [63:0]  serial;
	logic [255:0] digest;
	logic         host_done;
	logic         pass;
	logic         busy_b;
	logic         busy_h;
	logic         done_b_seen = 1'b0;
	logic [31:0]  seed = 32'h2551_fd73;
	logic [7:0]   mem [384];
	logic [8:0]   m_ptr = 9'h000;
	logic         m_wren = 1'b0;
	logic [7:0]   m_cmd = 8'h00;
	logic [7:0]   m_cfg = 8'h00;
	int           miscompares = 0;
	int           check_count = 0;
	int           cycles = 0;
	hax_if bus_a ();
	hax_if bus_b ();
	hax_dev #(.CHIP_IDENT(IDENT), .CONST_DATA(CDATA)) i_hax_dev (.CLK(clk), .RST(rst), .BUS(bus_a),
		.SECRET(secret), .UNIQUE_SERIAL(serial), .BUSY());
	hax_dev #(.CHIP_IDENT(IDENT), .CONST_DATA(CDATA)) i_hax_dev_b (.CLK(clk), .RST(rst), .BUS(bus_b),
		.SECRET(secret), .UNIQUE_SERIAL(serial), .BUSY(busy_b));
	hax_host i_hax_host (.CLK(clk), .RST(rst), .BUS(bus_a), .START(start), .WITH_SERIAL(with_ser),
		.CHALLENGE(chal), .EXPECTED(exp_dig), .DIGEST(digest), .DONE(host_done), .PASS(pass), .BUSY(busy_h));
	hax_properties i_hax_properties (.CLK(clk), .RST(rst), .wr(bus_a.wr), .rd(bus_a.rd), .addr(bus_a.addr),
		.wdata(bus_a.wdata), .rdata(bus_a.rdata), .rvalid(bus_a.rvalid), .done(bus_a.done));
	always #12.5 clk = ~clk;
	// The second engine never has its done event enabled, so any done pulse there is a fault.
	always @(negedge clk) begin
		cycles <= cycles + 1;
		if (bus_b.done === 1'b1) done_b_seen <= 1'b1;
		if (cycles == 8000) begin
			chk(1'b0, "timeout");
			complete_run();
		end
	end
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], ^(seed & 32'h8020_0003)};
		return seed;
	endfunction
	function automatic logic [31:0] ror(input logic [31:0] x, input int n);
		return (x >> n) | (x << (32 - n));
	endfunction
	function automatic logic [255:0] sha(input logic [511:0] b);
		logic [31:0]  w [64];
		logic [31:0]  v [8];
		logic [31:0]  t1;
		logic [31:0]  t2;
		logic [255:0] r;
		for (int i = 0; i < 64; i++) begin
			if (i < 16) w[i] = b[511 - 32 * i -: 32];
			else w[i] = (ror(w[i-2], 17) ^ ror(w[i-2], 19) ^ (w[i-2] >> 10)) + w[i-7] + w[i-16]
				+ (ror(w[i-15], 7) ^ ror(w[i-15], 18) ^ (w[i-15] >> 3));
		end
		v = IV;
		for (int i = 0; i < 64; i++) begin
			t1 = v[7] + (ror(v[4], 6) ^ ror(v[4], 11) ^ ror(v[4], 25)) + ((v[4] & v[5]) ^ (~v[4] & v[6])) + K[i] + w[i];
			t2 = (ror(v[0], 2) ^ ror(v[0], 13) ^ ror(v[0], 22)) + ((v[0] & v[1]) ^ (v[0] & v[2]) ^ (v[1] & v[2]));
			for (int j = 7; j > 0; j--) v[j] = v[j-1] + ((j == 4) ? t1 : 32'h0000_0000);
			v[0] = t1 + t2;
		end
		for (int i = 0; i < 8; i++) r[255 - 32 * i -: 32] = v[i] + IV[i];
		return r;
	endfunction
	task automatic chk(input bit ok, input string msg);
		check_count++;
		if (!ok) begin
			miscompares++;
			$display("CHECK FAILED at %0t ns: %s", $time, msg);
		end
	endtask
	task automatic step();
		if (m_ptr != hax_pkg::MEM_TOP) m_ptr = m_ptr + 9'h001;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		bus_b.wr = 1'b1;
		bus_b.addr = a;
		bus_b.wdata = d;
		@(negedge clk);
		bus_b.wr = 1'b0;
		case (a)
			hax_pkg::A_CMD: m_cmd = d;
			hax_pkg::A_CFG: m_cfg = d & 8'h02;
			hax_pkg::A_MCTL: {m_wren, m_ptr[8]} = d[1:0];
			hax_pkg::A_MIDX: m_ptr[7:0] = d;
			hax_pkg::A_MDATA: begin
				if (m_wren) mem[m_ptr] = d;
				step();
			end
			default: ;
		endcase
	endtask
	task automatic rd(input logic [7:0] a);
		logic [7:0] e;
		case (a)
			hax_pkg::A_CMD: e = m_cmd;
			hax_pkg::A_CFG: e = m_cfg;
			hax_pkg::A_MCTL: e = {6'h00, m_wren, m_ptr[8]};
			hax_pkg::A_MIDX: e = m_ptr[7:0];
			hax_pkg::A_MDATA: e = mem[m_ptr];
			hax_pkg::A_CHIPID: e = IDENT;
			default: e = 8'h00;
		endcase
		@(negedge clk);
		bus_b.rd = 1'b1;
		bus_b.addr = a;
		@(negedge clk);
		bus_b.rd = 1'b0;
		chk(bus_b.rvalid === 1'b1 && bus_b.rdata === e && !$isunknown(e), "register read");
		if (a == hax_pkg::A_MDATA) step();
	endtask
	task automatic wdat(input int n);
		logic [31:0] r;
		for (int i = 0; i < n; i++) begin
			r = rnd();
			wr(hax_pkg::A_MDATA, r[7:0]);
		end
	endtask
	task automatic rdn(input int n);
		for (int i = 0; i < n; i++) rd(hax_pkg::A_MDATA);
	endtask
	task automatic host_run(input logic ser, input logic bad);
		logic [255:0] e;
		@(negedge clk);
		for (int i = 0; i < 5; i++) chal[32 * i +: 32] = rnd();
		e = sha(ser ? {secret, chal, serial, CDATA[127:0]} : {secret, chal, CDATA});
		with_ser = ser;
		exp_dig = e ^ {255'h0, bad};
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		chk(busy_h === 1'b1, "host sequencer not busy after start");
		for (int n = 0; n < 400 && host_done !== 1'b1; n++) @(negedge clk);
		chk(host_done === 1'b1 && digest === e, "host digest");
		chk(pass === !bad, "host verdict");
		chk(busy_h === 1'b0, "host sequencer still busy at the end");
	endtask
	task automatic complete_run();
		$display("checks %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		logic [159:0] cb;
		logic [255:0] d;
		bus_b.wr = 1'b0;
		bus_b.rd = 1'b0;
		bus_b.addr = 8'h00;
		bus_b.wdata = 8'h00;
		for (int i = 0; i < 5; i++) secret[32 * i +: 32] = rnd();
		serial = {rnd(), rnd()};
		repeat (6) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		// The memory is not reset, so the window is left out of the reset sweep.
		foreach (IV[i]) rd((i == 4 || i == 7) ? hax_pkg::A_CHIPID : 8'hF0 + 8'(i));
		rd(8'h10);
		// A failed run sits between two good ones; the third must be unaffected by it.
		for (int i = 0; i < 3; i++) host_run(i != 1, i == 1);
		wr(hax_pkg::A_MCTL, 8'h02);
		wr(hax_pkg::A_MIDX, 8'hFE);
		wdat(3);
		rd(hax_pkg::A_MCTL);
		rd(hax_pkg::A_MIDX);
		wr(hax_pkg::A_MCTL, 8'h03);
		wr(hax_pkg::A_MIDX, 8'h7E);
		wdat(3);
		rd(hax_pkg::A_MIDX);
		wr(hax_pkg::A_MCTL, 8'h01);
		wr(hax_pkg::A_MIDX, 8'h7E);
		wdat(1);
		wr(hax_pkg::A_MIDX, 8'h7E);
		rdn(2);
		wr(hax_pkg::A_MCTL, 8'h00);
		wr(hax_pkg::A_MIDX, 8'hFE);
		rdn(3);
		wr(hax_pkg::A_CMD, 8'h37);
		wr(hax_pkg::A_CFG, hax_pkg::CFG_EN_GO);
		repeat (3) @(negedge clk);
		rd(hax_pkg::A_CFG);
		wr(hax_pkg::A_CFG, 8'h01);
		rd(hax_pkg::A_CFG);
		wr(hax_pkg::A_MCTL, hax_pkg::MCTL_WR_BANK0);
		wr(hax_pkg::A_MIDX, 8'h00);
		wdat(20);
		for (int i = 0; i < 20; i++) cb[159 - 8 * i -: 8] = mem[i];
		wr(hax_pkg::A_CMD, hax_pkg::CMD_MAC_NOSER);
		wr(hax_pkg::A_CFG, hax_pkg::CFG_EN_GO);
		for (int n = 0; n < 4 && busy_b !== 1'b1; n++) @(negedge clk);
		chk(busy_b === 1'b1, "engine did not start");
		for (int n = 0; n < 300 && busy_b !== 1'b0; n++) @(negedge clk);
		d = sha({secret, cb, CDATA});
		for (int i = 0; i < 32; i++) mem[i] = d[255 - 8 * i -: 8];
		rd(hax_pkg::A_CFG);
		wr(hax_pkg::A_MIDX, 8'h00);
		rdn(32);
		chk(done_b_seen === 1'b0, "done while not enabled");
		complete_run();
	end
endmodule
